// file: gpio_defs.svh
`ifndef GPIO_DEFS_SVH
`define GPIO_DEFS_SVH

// register byte offsets
`define OFS_THIRD_PIN 12'h000
`define OFS_THIRD_LATCH 12'h004
`define OFS_THIRD_DIR 12'h008
`define OFS_FOURTH_PIN 12'h00c
`define OFS_FOURTH_LATCH 12'h010
`define OFS_FOURTH_DIR 12'h014
`define OFS_FIFTH_CTRL 12'h018
`define OFS_PERIPH_STAT 12'h01c

// field positions, reset values, write mask, address bits and transfer codes
`define PSP_SELECT_BIT 4
`define DIR_RESET 8'hff
`define LATCH_RESET 8'h00
`define CTRL_RESET 8'h07
`define CTRL_WMASK 8'h17
`define ADDR_LSB 2
`define ADDR_MSB 11
`define HTRANS_NONSEQ 2'h2
`define HTRANS_SEQ 2'h3

`endif

// file: gpio_pkg.sv
package gpio_pkg;

  typedef enum logic [1:0] {
    ph_idle = 2'b00,
    ph_write = 2'b01,
    ph_read = 2'b10
  } phase_t;

  // per-pin peripheral override: en forces direction, out_drv 1 means output
  typedef struct packed {
    logic [7:0] en;
    logic [7:0] out_drv;
    logic [7:0] data;
  } periph_override_t;

  typedef struct packed {
    logic [7:0] oe;
    logic [7:0] out;
  } pin_drive_t;

  typedef struct packed {
    phase_t phase;
    logic [11:0] addr;
    logic [31:0] rdata;
    logic [7:0] third_latch;
    logic [7:0] third_dir;
    logic [7:0] fourth_latch;
    logic [7:0] fourth_dir;
    logic [7:0] fifth_ctrl;
    logic [7:0] third_sync1;
    logic [7:0] third_sync2;
    logic [7:0] fourth_sync1;
    logic [7:0] fourth_sync2;
    logic [7:0] drv_third_oe;
    logic [7:0] drv_third_out;
    logic [7:0] drv_fourth_oe;
    logic [7:0] drv_fourth_out;
  } state_t;

endpackage

// file: dual_eight_bit_io_ports.sv
`timescale 1ns/1ps
`include "gpio_defs.svh"
module dual_eight_bit_io_ports (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic second_capture_pin_route,
  input wire gpio_pkg::periph_override_t third_periph,
  output gpio_pkg::pin_drive_t third_drive,
  input wire logic [7:0] third_pin_in,
  output gpio_pkg::pin_drive_t fourth_drive,
  input wire logic [7:0] fourth_pin_in,
  output logic [7:0] third_pin_sampled,
  output logic [7:0] fourth_pin_sampled,
  output logic parallel_slave_select,
  output logic second_capture_on_third_bit_one
);

  gpio_pkg::state_t r;
  gpio_pkg::state_t next_r;
  logic [7:0] third_oe;
  logic [7:0] third_out;
  logic [7:0] eff_en;

  //////////////////////////////////////////////////////////////////////////
  // pin muxing of the third port
  always_comb begin
    // second capture unit reaches bit 1 only when routed there
    eff_en = third_periph.en;
    eff_en[1] = third_periph.en[1] & second_capture_pin_route;
  end

  // bits 0,2..7 carry timer, capture, serial and USART functions
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_third
      always_comb begin
        if (eff_en[gi]) begin
          third_oe[gi] = third_periph.out_drv[gi];
          third_out[gi] = third_periph.data[gi];
        end else begin
          third_oe[gi] = ~r.third_dir[gi];
          third_out[gi] = r.third_latch[gi];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [31:0] wd;
    logic in_slave;
    wd = hwdata;
    in_slave = r.fifth_ctrl[`PSP_SELECT_BIT];
    next_r = r;
    next_r.third_sync1 = third_pin_in;
    next_r.third_sync2 = r.third_sync1;
    next_r.fourth_sync1 = fourth_pin_in;
    next_r.fourth_sync2 = r.fourth_sync1;
    // write data phase
    if (r.phase == gpio_pkg::ph_write) begin
      unique case (r.addr)
        `OFS_THIRD_PIN, `OFS_THIRD_LATCH: next_r.third_latch = wd[7:0];
        `OFS_THIRD_DIR: next_r.third_dir = wd[7:0];
        `OFS_FOURTH_PIN, `OFS_FOURTH_LATCH: next_r.fourth_latch = wd[7:0];
        `OFS_FOURTH_DIR: next_r.fourth_dir = wd[7:0];
        `OFS_FIFTH_CTRL: next_r.fifth_ctrl = (wd[7:0] & `CTRL_WMASK) | (r.fifth_ctrl & ~`CTRL_WMASK);
        default: next_r.third_dir = r.third_dir;
      endcase
    end
    // address phase
    next_r.phase = gpio_pkg::ph_idle;
    next_r.rdata = r.rdata;
    if (hsel && hready && (htrans == `HTRANS_NONSEQ || htrans == `HTRANS_SEQ)) begin
      next_r.addr = haddr[`ADDR_MSB:0];
      next_r.phase = hwrite ? gpio_pkg::ph_write : gpio_pkg::ph_read;
      next_r.rdata = 32'h0000_0000;
      unique case ({haddr[`ADDR_MSB:`ADDR_LSB], 2'b00})
        `OFS_THIRD_PIN: next_r.rdata[7:0] = r.third_sync2;
        `OFS_THIRD_LATCH: next_r.rdata[7:0] = r.third_latch;
        `OFS_THIRD_DIR: next_r.rdata[7:0] = r.third_dir;
        `OFS_FOURTH_PIN: next_r.rdata[7:0] = r.fourth_sync2;
        `OFS_FOURTH_LATCH: next_r.rdata[7:0] = r.fourth_latch;
        `OFS_FOURTH_DIR: next_r.rdata[7:0] = r.fourth_dir;
        `OFS_FIFTH_CTRL: next_r.rdata[7:0] = r.fifth_ctrl;
        `OFS_PERIPH_STAT: next_r.rdata[7:0] = eff_en;
        default: next_r.rdata = 32'h0000_0000;
      endcase
    end
    // registered pin drivers
    next_r.drv_third_oe = third_oe;
    next_r.drv_third_out = third_out;
    // slave mode releases the fourth port to the parallel slave logic
    next_r.drv_fourth_oe = in_slave ? 8'h00 : ~r.fourth_dir;
    next_r.drv_fourth_out = r.fourth_latch;
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.third_dir <= `DIR_RESET;
      r.fourth_dir <= `DIR_RESET;
      r.third_latch <= `LATCH_RESET;
      r.fourth_latch <= `LATCH_RESET;
      r.fifth_ctrl <= `CTRL_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r.rdata;
  assign third_drive.oe = r.drv_third_oe;
  assign third_drive.out = r.drv_third_out;
  assign fourth_drive.oe = r.drv_fourth_oe;
  assign fourth_drive.out = r.drv_fourth_out;
  assign third_pin_sampled = r.third_sync2;
  assign fourth_pin_sampled = r.fourth_sync2;
  assign parallel_slave_select = r.fifth_ctrl[`PSP_SELECT_BIT];
  assign second_capture_on_third_bit_one = second_capture_pin_route;

endmodule

// file: gpio_chk_sva.sv
`timescale 1ns/1ps
module gpio_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic second_capture_pin_route,
  input wire logic second_capture_on_third_bit_one,
  input wire logic parallel_slave_select,
  input wire gpio_pkg::periph_override_t third_periph,
  input wire gpio_pkg::pin_drive_t third_drive,
  input wire gpio_pkg::pin_drive_t fourth_drive
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_out0;
    third_periph.en[0] && third_periph.out_drv[0];
  endsequence
  sequence s_drv0;
    third_drive.oe[0] && third_drive.out[0] == $past(third_periph.data[0]);
  endsequence
  a_ready_high: assert property (hreadyout) else $error("ready");
  a_resp_okay: assert property (!hresp) else $error("resp");
  a_route_copy: assert property ($stable(second_capture_pin_route) |->
    second_capture_on_third_bit_one == second_capture_pin_route) else $error("route");
  a_force_out: assert property (s_out0 |=> s_drv0) else $error("out");
  a_force_in: assert property (third_periph.en[2] && !third_periph.out_drv[2]
    |=> !third_drive.oe[2]) else $error("in");
  a_route_pin: assert property (second_capture_pin_route && third_periph.en[1]
    && third_periph.out_drv[1] |=> third_drive.oe[1]) else $error("pin1");
  a_psp_float: assert property (parallel_slave_select && $past(parallel_slave_select)
    |-> fourth_drive.oe == 8'h00) else $error("psp");
  a_reset_float: assert property (disable iff (1'b0) !hresetn |=>
    third_drive.oe == 8'h00 && fourth_drive.oe == 8'h00) else $error("reset");
endmodule
bind dual_eight_bit_io_ports gpio_chk chk (.hclk, .hresetn, .hreadyout, .hresp,
  .second_capture_pin_route, .second_capture_on_third_bit_one, .parallel_slave_select,
  .third_periph, .third_drive, .fourth_drive);

// file: gpio_pins.sv
`timescale 1ns/1ps
module gpio_pins (
  input wire gpio_pkg::pin_drive_t d3,
  input wire gpio_pkg::pin_drive_t d4,
  input wire logic [7:0] e3,
  input wire logic [7:0] e4,
  output logic [7:0] p3,
  output logic [7:0] p4
);
  // released pins show the outside source
  assign p3 = (d3.oe & d3.out) | (~d3.oe & e3);
  assign p4 = (d4.oe & d4.out) | (~d4.oe & e4);
endmodule

// file: dual_eight_bit_io_ports_test.sv
`timescale 1ns/1ps
module dual_eight_bit_io_ports_test;
  logic hclk = 0, hresetn = 0, hwrite = 0, route = 1;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic hreadyout, hresp, psp, cap;
  logic [7:0] p3, p4, s3, s4;
  gpio_pkg::periph_override_t per = '0;
  gpio_pkg::pin_drive_t d3, d4;
  int errors = 0, check_count = 0;
  dual_eight_bit_io_ports uut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .second_capture_pin_route(route), .third_periph(per), .third_drive(d3),
    .third_pin_in(p3), .fourth_drive(d4), .fourth_pin_in(p4), .third_pin_sampled(s3),
    .fourth_pin_sampled(s4), .parallel_slave_select(psp), .second_capture_on_third_bit_one(cap));
  gpio_pins pins (.d3, .d4, .e3(8'ha5), .e4(8'h96), .p3, .p4);
  initial forever #12.5 hclk = ~hclk;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task tally_and_finish;
    if (errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      errors++;
      tally_and_finish;
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    r = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk("read", e, r);
  endtask
  task settle;
    repeat (3) @(posedge hclk);
    #1;
  endtask
  task t_reset;
    chk("oe", 32'h0, {d3.oe, d4.oe});
    rd(8'h08, 32'hff);
    rd(8'h14, 32'hff);
  endtask
  task t_third;
    xfer(1'b1, 8'h04, 32'h5a);
    xfer(1'b1, 8'h08, 32'h0f);
    settle;
    chk("drive3", 32'hf050, {d3.oe, d3.out & d3.oe});
    chk("sample3", 32'h55, {24'h0, s3});
    rd(8'h04, 32'h5a);
    rd(8'h00, 32'h55);
  endtask
  task t_force;
    xfer(1'b1, 8'h08, 32'h01);
    per <= '{en: 8'h07, out_drv: 8'h03, data: 8'h01};
    settle;
    chk("force", 32'hfb01, {d3.oe, d3.out & 8'h01});
    rd(8'h08, 32'h01);
    route <= 1'b0;
    per <= '0;
    settle;
    chk("route", 32'h0, {31'h0, cap});
  endtask
  task t_fourth;
    xfer(1'b1, 8'h10, 32'h3c);
    xfer(1'b1, 8'h14, 32'h0f);
    settle;
    chk("drive4", 32'hf030, {d4.oe, d4.out & d4.oe});
    chk("sample4", 32'h36, {24'h0, s4});
    rd(8'h10, 32'h3c);
    rd(8'h0c, 32'h36);
    xfer(1'b1, 8'h18, 32'hff);
    settle;
    chk("psp", 32'h1, {d4.oe, 7'h0, psp});
    rd(8'h18, 32'h17);
    rd(8'h40, 32'h0);
  endtask
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_third;
    t_force;
    t_fourth;
    tally_and_finish;
  end
endmodule
